//--- rtl/dec_map.svh
// Offsets, field positions, reset values and widths of the directory entry cache
`ifndef DEC_MAP_SVH
`define DEC_MAP_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DEC_ADDR_W 8
`define DEC_CTRL_OFS 8'h00
`define DEC_STATUS_OFS 8'h04
`define DEC_HITS_OFS 8'h08
`define DEC_FILLS_OFS 8'h0C

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define DEC_CTRL_CM_BIT 0
`define DEC_CTRL_NXE_BIT 1
`define DEC_CTRL_STAGE_TWO_EXECUTE_ENABLE_BIT 2
`define DEC_CTRL_EXTENDED_ACCESSED_ENABLE_BIT 3
`define DEC_CTRL_FLUSH_BIT 4
`define DEC_CTRL_RESET 4'h0
`define DEC_ZERO_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Entry geometry
// ----------------------------------------------------------------
`define DEC_TAG_LO 21
`define DEC_TAG_HI 47
`define DEC_HTRANS_NONSEQ 2'b10

`endif

//--- rtl/dec_pkg.sv
// Types used by the directory entry cache; its entry store sees them only as raw words
package dec_pkg;

    // ----------------------------------------------------------------
    // Walk kinds and fill sequencing
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WALK_FIRST,
        WALK_SECOND,
        WALK_NESTED
    } walk_t;

    typedef enum logic [1:0] {
        FILL_IDLE,
        FILL_ACCESS,
        FILL_WRITE
    } fill_state_t;

    // ----------------------------------------------------------------
    // One cached directory entry
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [26:0] tag;
        walk_t walk;
        logic [15:0] domain;
        logic [19:0] pasid;
        logic [39:0] base;
        logic read;
        logic write;
        logic user;
        logic exec_disable;
        logic cache_disable;
        logic write_through;
    } entry_t;

endpackage : dec_pkg

//--- rtl/entry_store.sv
// Small entry memory with one write port and a registered read port
`timescale 1ns/1ps
module entry_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int IDX_W = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [IDX_W-1:0] wr_idx_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read port
    input wire logic rd_en_in,
    input wire logic [IDX_W-1:0] rd_idx_in,
    output logic [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_idx_in] <= wr_data_in;
        end
    end

    // Old data on a same-cycle write; the cache tolerates stale reads
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rd_data_out <= '0;
        end else if (rd_en_in) begin
            rd_data_out <= mem[rd_idx_in];
        end
    end

endmodule : entry_store

//--- rtl/directory_entry_cache.sv
// Directory-level paging-structure cache with an AHB-Lite control slave
`timescale 1ns/1ps
`include "dec_map.svh"
module directory_entry_cache #(
    parameter int ENTRIES = 8,
    parameter int IDX_W = 3,
    parameter int MAX_GUEST_ADDR_WIDTH = 48
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Lookup request from the translation pipeline
    input wire logic lookup_valid_in,
    input wire logic [1:0] lookup_walk_in,
    input wire logic [47:0] lookup_addr_in,
    input wire logic [15:0] lookup_domain_in,
    input wire logic [19:0] lookup_pasid_in,
    // Lookup answer
    output logic lookup_done_out,
    output logic lookup_hit_out,
    output logic [39:0] lookup_base_out,
    output logic lookup_read_out,
    output logic lookup_write_out,
    output logic lookup_user_out,
    output logic lookup_exec_disable_out,
    output logic lookup_cache_disable_out,
    output logic lookup_write_through_out,
    // Walk result from the page walker
    input wire logic fill_valid_in,
    input wire logic [1:0] fill_walk_in,
    input wire logic [47:0] fill_addr_in,
    input wire logic [15:0] fill_domain_in,
    input wire logic [19:0] fill_pasid_in,
    input wire logic [39:0] fill_base_in,
    input wire logic fill_fault_in,
    input wire logic fill_maps_page_in,
    input wire logic [2:0] fill_present_in,
    input wire logic [2:0] fill_rsvd_zero_in,
    input wire logic [2:0] fill_read_in,
    input wire logic [2:0] fill_write_in,
    input wire logic [2:0] fill_user_in,
    input wire logic [2:0] fill_exec_disable_in,
    input wire logic [2:0] fill_exec_in,
    input wire logic fill_cache_disable_in,
    input wire logic fill_write_through_in,
    input wire logic [2:0] fill_accessed_in,
    input wire logic [2:0] fill_ext_accessed_in,
    input wire logic [2:0] fill_s2_read_in,
    input wire logic fill_s2_write_in,
    input wire logic fill_s2_exec_in,
    output logic fill_ready_out,
    // Accessed-flag update handshake with the walker
    output logic access_set_req_out,
    output logic [2:0] access_set_mask_out,
    output logic access_set_ext_out,
    input wire logic access_set_ack_in,
    input wire logic access_set_ok_in
);

    localparam int ENTRY_W = $bits(dec_pkg::entry_t);
    localparam logic [26:0] SL_TAG_MASK =
        27'((28'(1) << (MAX_GUEST_ADDR_WIDTH - `DEC_TAG_LO)) - 28'(1));

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic caching_mode;
    logic no_execute_enable;
    logic stage_two_execute_enable;
    logic extended_accessed_enable;
    logic flush;
    logic [31:0] hit_count;
    logic [31:0] fill_count;
    logic wr_pend;
    logic [7:0] wr_addr;

    dec_pkg::fill_state_t fill_state;
    dec_pkg::entry_t fill_entry;
    logic [ENTRIES-1:0] valid;
    logic lk_pend;

    // ----------------------------------------------------------------
    // Tag formation
    // ----------------------------------------------------------------
    function automatic logic [26:0] tag_of(input dec_pkg::walk_t w, input logic [47:0] a);
        logic [26:0] t;
        t = a[`DEC_TAG_HI:`DEC_TAG_LO];
        if (w == dec_pkg::WALK_SECOND) begin
            t = t & SL_TAG_MASK;
        end
        return t;
    endfunction : tag_of

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    logic ahb_take;
    logic [7:0] ahb_ofs;
    assign ahb_take = hsel_in && hready_in && (htrans_in == `DEC_HTRANS_NONSEQ);
    assign ahb_ofs = haddr_in[`DEC_ADDR_W-1:0];

    always_ff @(posedge clk_in) begin
        hreadyout_out <= rstn_in;
        hresp_out <= 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else if (hready_in) begin
            wr_pend <= ahb_take && hwrite_in;
            wr_addr <= ahb_ofs;
        end
    end

    // Read data captured in the address phase so it leaves a flop
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            hrdata_out <= `DEC_ZERO_WORD;
        end else if (ahb_take && !hwrite_in) begin
            if (ahb_ofs == `DEC_CTRL_OFS) begin
                hrdata_out <= {28'h000_0000, extended_accessed_enable,
                               stage_two_execute_enable, no_execute_enable, caching_mode};
            end else if (ahb_ofs == `DEC_STATUS_OFS) begin
                hrdata_out <= {30'h0000_0000, lk_pend, fill_state != dec_pkg::FILL_IDLE};
            end else if (ahb_ofs == `DEC_HITS_OFS) begin
                hrdata_out <= hit_count;
            end else if (ahb_ofs == `DEC_FILLS_OFS) begin
                hrdata_out <= fill_count;
            end else begin
                hrdata_out <= `DEC_ZERO_WORD;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            {extended_accessed_enable, stage_two_execute_enable,
             no_execute_enable, caching_mode} <= `DEC_CTRL_RESET;
            flush <= 1'b0;
        end else begin
            flush <= 1'b0;
            if (wr_pend && wr_addr == `DEC_CTRL_OFS) begin
                caching_mode <= hwdata_in[`DEC_CTRL_CM_BIT];
                no_execute_enable <= hwdata_in[`DEC_CTRL_NXE_BIT];
                stage_two_execute_enable <= hwdata_in[`DEC_CTRL_STAGE_TWO_EXECUTE_ENABLE_BIT];
                extended_accessed_enable <= hwdata_in[`DEC_CTRL_EXTENDED_ACCESSED_ENABLE_BIT];
                flush <= hwdata_in[`DEC_CTRL_FLUSH_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Fill qualification and entry composition
    // ----------------------------------------------------------------
    dec_pkg::walk_t f_walk;
    dec_pkg::entry_t next_fill_entry;
    logic f_cond;
    logic f_allow;
    logic [2:0] f_need;
    logic f_nx;
    logic f_sx;

    assign f_walk = dec_pkg::walk_t'(fill_walk_in);
    assign f_nx = no_execute_enable && (|fill_exec_disable_in);
    assign f_sx = stage_two_execute_enable && !(&fill_exec_in);

    always_comb begin
        next_fill_entry = '0;
        next_fill_entry.tag = tag_of(f_walk, fill_addr_in);
        next_fill_entry.walk = f_walk;
        next_fill_entry.domain = fill_domain_in;
        next_fill_entry.base = fill_base_in;
        f_cond = 1'b0;
        case (f_walk)
            dec_pkg::WALK_FIRST: begin
                next_fill_entry.pasid = fill_pasid_in;
                next_fill_entry.read = 1'b1;
                next_fill_entry.write = &fill_write_in;
                next_fill_entry.user = &fill_user_in;
                next_fill_entry.exec_disable = f_nx;
                next_fill_entry.cache_disable = fill_cache_disable_in;
                next_fill_entry.write_through = fill_write_through_in;
                f_cond = (&fill_present_in) && (&fill_rsvd_zero_in);
            end
            dec_pkg::WALK_SECOND: begin
                next_fill_entry.read = &fill_read_in;
                next_fill_entry.write = &fill_write_in;
                next_fill_entry.user = 1'b1;
                next_fill_entry.exec_disable = f_sx;
                f_cond = (&(fill_read_in | fill_write_in)) && (&fill_rsvd_zero_in);
            end
            dec_pkg::WALK_NESTED: begin
                next_fill_entry.pasid = fill_pasid_in;
                next_fill_entry.read = 1'b1;
                next_fill_entry.write = (&fill_write_in) && fill_s2_write_in;
                next_fill_entry.user = &fill_user_in;
                next_fill_entry.exec_disable = f_nx || (stage_two_execute_enable
                    && !fill_s2_exec_in);
                next_fill_entry.cache_disable = fill_cache_disable_in;
                next_fill_entry.write_through = fill_write_through_in;
                f_cond = (&fill_present_in) && (&fill_rsvd_zero_in)
                         && (&fill_s2_read_in);
            end
        endcase
    end

    // Faulted walks only enter when caching mode is set, tagged as usual
    assign f_allow = !fill_maps_page_in
                     && ((f_cond && !fill_fault_in)
                         || (caching_mode && fill_fault_in));
    assign f_need = (f_walk == dec_pkg::WALK_SECOND) ? 3'b000 :
                    (~fill_accessed_in
                     | ({3{extended_accessed_enable}} & ~fill_ext_accessed_in));

    // ----------------------------------------------------------------
    // Fill sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            fill_state <= dec_pkg::FILL_IDLE;
            fill_entry <= '0;
            fill_ready_out <= 1'b0;
            access_set_req_out <= 1'b0;
            access_set_mask_out <= 3'h0;
            access_set_ext_out <= 1'b0;
        end else begin
            case (fill_state)
                dec_pkg::FILL_IDLE: begin
                    fill_ready_out <= 1'b1;
                    if (fill_valid_in && fill_ready_out && f_allow) begin
                        fill_entry <= next_fill_entry;
                        fill_ready_out <= 1'b0;
                        if (|f_need && !fill_fault_in) begin
                            // Memory flags must be set before the entry appears
                            access_set_req_out <= 1'b1;
                            access_set_mask_out <= f_need;
                            access_set_ext_out <= extended_accessed_enable;
                            fill_state <= dec_pkg::FILL_ACCESS;
                        end else begin
                            fill_state <= dec_pkg::FILL_WRITE;
                        end
                    end
                end
                dec_pkg::FILL_ACCESS: begin
                    if (access_set_ack_in) begin
                        access_set_req_out <= 1'b0;
                        access_set_mask_out <= 3'h0;
                        access_set_ext_out <= 1'b0;
                        // A refused update, e.g. no stage-two write, drops the fill
                        if (access_set_ok_in) begin
                            fill_state <= dec_pkg::FILL_WRITE;
                        end else begin
                            fill_state <= dec_pkg::FILL_IDLE;
                        end
                    end
                end
                dec_pkg::FILL_WRITE: begin
                    fill_state <= dec_pkg::FILL_IDLE;
                end
                default: begin
                    fill_state <= dec_pkg::FILL_IDLE;
                end
            endcase
        end
    end

    logic fill_wr;
    logic [IDX_W-1:0] fill_idx;
    assign fill_wr = (fill_state == dec_pkg::FILL_WRITE);
    assign fill_idx = fill_entry.tag[IDX_W-1:0];

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            fill_count <= `DEC_ZERO_WORD;
        end else if (fill_wr) begin
            fill_count <= fill_count + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Valid bits
    // ----------------------------------------------------------------
    // Flush drops everything; a fill in the same cycle still lands
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            valid <= '0;
        end else begin
            if (flush) begin
                valid <= '0;
            end
            if (fill_wr) begin
                valid[fill_idx] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Lookup pipeline
    // ----------------------------------------------------------------
    dec_pkg::walk_t lk_walk;
    logic [26:0] lk_tag;
    logic [15:0] lk_domain;
    logic [19:0] lk_pasid;
    logic [IDX_W-1:0] lk_idx;
    logic [26:0] req_tag;
    logic [ENTRY_W-1:0] rd_word;
    dec_pkg::entry_t rd_entry;
    logic lk_match;

    assign req_tag = tag_of(dec_pkg::walk_t'(lookup_walk_in), lookup_addr_in);
    assign rd_entry = dec_pkg::entry_t'(rd_word);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lk_pend <= 1'b0;
            lk_walk <= dec_pkg::WALK_FIRST;
            lk_tag <= '0;
            lk_domain <= '0;
            lk_pasid <= '0;
            lk_idx <= '0;
        end else begin
            lk_pend <= lookup_valid_in;
            if (lookup_valid_in) begin
                lk_walk <= dec_pkg::walk_t'(lookup_walk_in);
                lk_tag <= req_tag;
                lk_domain <= lookup_domain_in;
                lk_pasid <= lookup_pasid_in;
                lk_idx <= req_tag[IDX_W-1:0];
            end
        end
    end

    entry_store #(
        .WIDTH(ENTRY_W),
        .DEPTH(ENTRIES),
        .IDX_W(IDX_W)
    ) u_store (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_en_in(fill_wr),
        .wr_idx_in(fill_idx),
        .wr_data_in(fill_entry),
        .rd_en_in(lookup_valid_in),
        .rd_idx_in(req_tag[IDX_W-1:0]),
        .rd_data_out(rd_word)
    );

    // Second-level entries carry no PASID, so it is not compared
    assign lk_match = valid[lk_idx] && !flush
                      && rd_entry.tag == lk_tag
                      && rd_entry.walk == lk_walk
                      && rd_entry.domain == lk_domain
                      && (lk_walk == dec_pkg::WALK_SECOND
                          || rd_entry.pasid == lk_pasid);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lookup_done_out <= 1'b0;
            lookup_hit_out <= 1'b0;
            lookup_base_out <= '0;
            lookup_read_out <= 1'b0;
            lookup_write_out <= 1'b0;
            lookup_user_out <= 1'b0;
            lookup_exec_disable_out <= 1'b0;
            lookup_cache_disable_out <= 1'b0;
            lookup_write_through_out <= 1'b0;
        end else begin
            lookup_done_out <= lk_pend;
            lookup_hit_out <= lk_pend && lk_match;
            if (lk_pend && lk_match) begin
                lookup_base_out <= rd_entry.base;
                lookup_read_out <= rd_entry.read;
                lookup_write_out <= rd_entry.write;
                lookup_user_out <= rd_entry.user;
                lookup_exec_disable_out <= rd_entry.exec_disable;
                lookup_cache_disable_out <= rd_entry.cache_disable;
                lookup_write_through_out <= rd_entry.write_through;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            hit_count <= `DEC_ZERO_WORD;
        end else if (lk_pend && lk_match) begin
            hit_count <= hit_count + 32'h0000_0001;
        end
    end

endmodule : directory_entry_cache

//--- tb/directory_entry_cache_chk.sv
// Checker of the directory entry cache handshakes
`timescale 1ns/1ps
module directory_entry_cache_chk (
    // Watched ports
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic lookup_valid_in,
    input wire logic lookup_done_out,
    input wire logic lookup_hit_out,
    input wire logic fill_valid_in,
    input wire logic fill_maps_page_in,
    input wire logic fill_ready_out,
    input wire logic access_set_req_out,
    input wire logic access_set_ack_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_done_lat: assert property (
        lookup_valid_in |-> ##2 lookup_done_out) else $error("lookup answer late");
    a_done_cause: assert property (
        lookup_done_out |-> $past(lookup_valid_in, 2)) else $error("answer without lookup");
    a_hit_done: assert property (
        lookup_hit_out |-> lookup_done_out) else $error("hit outside an answer");
    a_reset_miss: assert property (
        $rose(rstn_in) |-> !lookup_hit_out [*4]) else $error("hit right after reset");
    a_req_hold: assert property (
        access_set_req_out && !access_set_ack_in |=> access_set_req_out) else $error("req lost");
    a_req_drop: assert property (
        access_set_req_out && access_set_ack_in |=> !access_set_req_out) else $error("req stuck");
    a_req_busy: assert property (
        access_set_req_out |-> !fill_ready_out) else $error("ready during update");
    a_page_drop: assert property (
        fill_valid_in && fill_ready_out && fill_maps_page_in |=> fill_ready_out)
        else $error("large page fill taken");
    c_hit: cover property (lookup_hit_out);
    c_update: cover property (access_set_req_out && access_set_ack_in);
    c_page: cover property (fill_valid_in && fill_maps_page_in && fill_ready_out);
endmodule : directory_entry_cache_chk
bind directory_entry_cache directory_entry_cache_chk directory_entry_cache_chk_inst (.*);

//--- tb/walker_model.sv
// Walker model answering accessed-flag updates
`timescale 1ns/1ps
module walker_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Update handshake
    input wire logic req_in,
    input wire logic ok_mode_in,
    input wire logic slow_in,
    output logic ack_out,
    output logic ok_out
);
    logic [2:0] cnt;
    logic go;
    // Answers after one or five cycles; ok is junk outside the ack
    assign go = req_in && !ack_out && cnt == (slow_in ? 3'h4 : 3'h0);
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            {cnt, ack_out, ok_out} <= 5'h00;
        end else begin
            ack_out <= go;
            ok_out <= go ? ok_mode_in : ~ok_out;
            cnt <= (req_in && !ack_out) ? cnt + 3'h1 : 3'h0;
        end
    end
endmodule : walker_model

//--- tb/directory_entry_cache_test.sv
// Self-checking bench of the directory entry cache
`timescale 1ns/1ps
module directory_entry_cache_test;
    logic clk_in, rstn_in, hsel_in, hwrite_in, hready_in, lookup_valid_in, fill_valid_in;
    logic fill_fault_in, fill_maps_page_in, fill_cache_disable_in, fill_write_through_in;
    logic fill_s2_write_in, fill_s2_exec_in, access_set_ack_in, access_set_ok_in, okm, slow;
    logic hreadyout_out, hresp_out, lookup_done_out, lookup_hit_out, lookup_read_out;
    logic lookup_write_out, lookup_user_out, lookup_exec_disable_out, lookup_cache_disable_out;
    logic lookup_write_through_out, fill_ready_out, access_set_req_out, access_set_ext_out;
    logic [1:0] htrans_in, lookup_walk_in, fill_walk_in, w;
    logic [2:0] hsize_in, fill_present_in, fill_rsvd_zero_in, fill_read_in, fill_write_in;
    logic [2:0] fill_user_in, fill_exec_disable_in, fill_exec_in, fill_accessed_in;
    logic [2:0] fill_ext_accessed_in, fill_s2_read_in, access_set_mask_out;
    logic [4:0] cfg;
    logic [15:0] lookup_domain_in, fill_domain_in;
    logic [19:0] lookup_pasid_in, fill_pasid_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [39:0] fill_base_in, lookup_base_out;
    logic [47:0] lookup_addr_in, fill_addr_in;
    wire [5:0] lf = {lookup_read_out, lookup_write_out, lookup_user_out, lookup_exec_disable_out,
        lookup_cache_disable_out, lookup_write_through_out};
    int error_cnt = 0;
    int compares = 0;
    assign hready_in = hreadyout_out;
    directory_entry_cache #(.MAX_GUEST_ADDR_WIDTH(40)) directory_entry_cache_inst (.*);
    walker_model walker_model_inst (.clk_in, .rstn_in, .req_in(access_set_req_out),
        .ok_mode_in(okm), .slow_in(slow), .ack_out(access_set_ack_in), .ok_out(access_set_ok_in));
    task check(input logic [47:0] s, input logic [47:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask : check
    task test_done;
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    function logic [5:0] exp_f;
        logic x;
        x = cfg[1] & |fill_exec_disable_in;
        case (fill_walk_in)
            2'h0: exp_f = {1'b1, &fill_write_in, &fill_user_in, x,
                fill_cache_disable_in, fill_write_through_in};
            2'h1: exp_f = {&fill_read_in, &fill_write_in, 2'h2 | (cfg[2] & ~&fill_exec_in), 2'h0};
            default: exp_f = {1'b1, &fill_write_in & fill_s2_write_in, &fill_user_in,
                x | (cfg[2] & ~fill_s2_exec_in), 2'h0};
        endcase
    endfunction : exp_f
    // Bounded wait on hready (0) or fill ready (1); update mask checked meanwhile
    task wait_on(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (access_set_req_out === 1'b1) begin
                check(access_set_mask_out, 3'(~fill_accessed_in | ~fill_ext_accessed_in & {3{cfg[3]}}));
            end
        end while ((k ? fill_ready_out : hready_in) !== 1'b1 && n < 99);
        if (n > 98) begin
            error_cnt++;
            test_done();
        end
    endtask : wait_on
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {htrans_in, haddr_in, hwrite_in} <= {2'h2, 24'h00_0000, a, wr};
        wait_on(0);
        {htrans_in, hwdata_in} <= {2'h0, d};
        wait_on(0);
        rd = hrdata_out;
    endtask : ahb
    task look(input logic h, input logic [47:0] a, input logic [15:0] d, input logic [19:0] p,
        input logic [1:0] wk);
        @(posedge clk_in);
        {lookup_valid_in, lookup_walk_in} <= {1'b1, wk};
        lookup_addr_in <= fill_addr_in ^ a;
        {lookup_domain_in, lookup_pasid_in} <= {fill_domain_in ^ d, fill_pasid_in ^ p};
        @(posedge clk_in);
        lookup_valid_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check(lookup_done_out, 1'b1);
        check(lookup_hit_out, h);
        if (h) begin
            check(lf, exp_f());
            check(lookup_base_out, fill_base_in);
        end
    endtask : look
    task rnd(input logic [1:0] wk, input logic [2:0] nrw);
        logic [31:0] q;
        logic [127:0] r;
        q = $urandom;
        r = {$urandom, $urandom, $urandom, $urandom};
        {fill_addr_in, fill_base_in, fill_domain_in, fill_pasid_in} <= r[123:0];
        {fill_user_in, fill_exec_disable_in, fill_exec_in, fill_ext_accessed_in} <= q[11:0];
        {fill_s2_write_in, fill_s2_exec_in, slow} <= q[14:12];
        {fill_cache_disable_in, fill_write_through_in} <= (wk == 2'h2) ? 2'h0 : q[16:15];
        {fill_write_in, fill_read_in} <= {q[19:17], q[22:20] | ~q[19:17]} & ~{nrw, nrw};
        {fill_fault_in, fill_maps_page_in, okm, fill_walk_in} <= {3'h1, wk};
    endtask : rnd
    task try(input logic h, input logic [2:0] pr, rz, s2, nrw, ac, fm, input logic [1:0] wk);
        rnd(wk, nrw);
        {fill_present_in, fill_rsvd_zero_in, fill_s2_read_in, fill_accessed_in} <= {pr, rz, s2, ac};
        {fill_fault_in, fill_maps_page_in, okm} <= fm;
        wait_on(1);
        fill_valid_in <= 1'b1;
        @(posedge clk_in);
        fill_valid_in <= 1'b0;
        wait_on(1);
        look(h, 48'h0, 16'h0, 20'h0, wk);
    endtask : try
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        rd = $urandom(29);
        {rstn_in, hsel_in, hsize_in, cfg} <= {2'h1, 3'h2, 5'h00};
        {hwrite_in, lookup_valid_in, fill_valid_in, htrans_in, haddr_in, hwdata_in} <= '0;
        {lookup_walk_in, lookup_addr_in, lookup_domain_in, lookup_pasid_in} <= '0;
        rnd(2'h0, 3'h0);
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, 8'(i * 4), 32'h0000_0000);
            check(rd, 48'h0);
        end
        for (int i = 0; i < 12; i++) begin
            w = 2'(i % 3);
            cfg = (i > 5) ? 5'h06 : 5'h00;
            ahb(1'b1, 8'h00, {27'h0, cfg});
            try(1'b1, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7, 3'h1, w);
            look(1'b0, 48'h0, 16'h0001, 20'h0, w);
            look(w == 2'h1, 48'h0, 16'h0, 20'h0_0001, w);
            look(w == 2'h1, 48'h8000_0000_0000, 16'h0, 20'h0, w);
            look(1'b0, 48'h0000_0020_0000, 16'h0, 20'h0, w);
            look(1'b0, 48'h0, 16'h0, 20'h0, 2'h3);
        end
        try(1'b0, 3'h3, 3'h7, 3'h7, 3'h0, 3'h7, 3'h1, 2'h0);
        try(1'b0, 3'h7, 3'h5, 3'h7, 3'h0, 3'h7, 3'h1, 2'h0);
        try(1'b0, 3'h7, 3'h7, 3'h6, 3'h0, 3'h7, 3'h1, 2'h2);
        try(1'b0, 3'h7, 3'h7, 3'h7, 3'h2, 3'h7, 3'h1, 2'h1);
        try(1'b0, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7, 3'h3, 2'h0);
        try(1'b0, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7, 3'h5, 2'h0);
        try(1'b1, 3'h7, 3'h7, 3'h7, 3'h0, 3'h5, 3'h1, 2'h0);
        try(1'b0, 3'h7, 3'h7, 3'h7, 3'h0, 3'h3, 3'h0, 2'h2);
        cfg = 5'h09;
        ahb(1'b1, 8'h00, {27'h0, cfg});
        try(1'b1, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7, 3'h5, 2'h0);
        try(1'b1, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7, 3'h1, 2'h0);
        ahb(1'b1, 8'h00, {27'h0, cfg | 5'h10});
        look(1'b0, 48'h0, 16'h0, 20'h0, 2'h0);
        test_done();
    end
endmodule : directory_entry_cache_test
